// *** hw/tao_trip_alarm_output.sv ***
// What this block does
// R1: alarm asserts while tripped after a fault, deasserts once the fault is cleared.
// R2: an output whose function selection is 05 presents the alarm function.
// R3: alarm reaches the assigned terminal a nominal 300 ms after the fault event.
// R4: alarm may go to either open-collector output or relay; relay defaults to alarm.
// R5: relay polarity defaults to normally closed, energised when no alarm.
// R6: normally closed: relay energises after power-up delay shorter than 2 seconds.
// R7: normally closed: trip de-energises relay; power loss releases it too.
// R8: normally open: relay energised only while a trip is present.
// R9: external circuit picks the contact pair matching its alarm convention.
// R10: alarm stays latched until a clear request is taken, then drops next edge.
`timescale 1ns/10ps
`default_nettype none
module tao_trip_alarm_output #(
	parameter int ALARM_DELAY_CYC = tao_pkg::ALARM_DELAY_CYC,
	parameter int STARTUP_DELAY_CYC = tao_pkg::STARTUP_DELAY_CYC
) (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic fault_event_in,
	input wire logic fault_clear_in,
	input wire logic [7:0] output_one_function_select_in,
	input wire logic [7:0] output_two_function_select_in,
	input wire logic [7:0] relay_function_select_in,
	input wire logic [7:0] relay_polarity_select_in,
	output logic trip_state_out,
	output logic trip_alarm_function_out,
	output logic output_one_out,
	output logic output_two_out,
	output logic relay_energise_out
);
	// both counters are 32 bits wide; a delay of a few seconds fits with room to spare
	localparam int OUT_COUNT = 2;
	localparam logic [31:0] DELAY_LAST = 32'(ALARM_DELAY_CYC - 1);
	localparam logic [31:0] START_LAST = 32'(STARTUP_DELAY_CYC - 1);

	// refuse delays the counters cannot serve, and a startup delay of 2 seconds or more
	if (ALARM_DELAY_CYC < 1 || STARTUP_DELAY_CYC < 1) begin : g_bad_delay
		$error("delay counts must be at least one cycle");
	end
	if (STARTUP_DELAY_CYC > tao_pkg::MAX_STARTUP_CYC) begin : g_bad_startup
		$error("startup delay must stay below 2 seconds");
	end

	typedef enum logic [1:0] {TAO_IDLE, TAO_DELAY, TAO_ALARM} tao_state_t;

	tao_state_t state;
	tao_state_t next_state;
	logic [31:0] delay_cnt;
	logic [31:0] next_delay_cnt;
	logic [31:0] start_cnt;
	logic [31:0] next_start_cnt;
	logic started;
	logic next_started;
	logic trip;
	logic alarm;
	logic next_alarm;
	logic clear_taken;
	logic relay_on;
	logic [7:0] term_select [OUT_COUNT];
	logic term_out [OUT_COUNT];

	// a clear that meets a fault in one cycle is dropped: the fault wins
	assign clear_taken = fault_clear_in && !fault_event_in;

	// trip latch: a fault arriving with a clear still trips, so the event is not lost
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			trip <= 1'b0;
		end else if (clk_en_in) begin
			if (fault_event_in) begin
				trip <= 1'b1; // R1
			end else if (fault_clear_in) begin
				trip <= 1'b0; // R10
			end
		end
	end

	// alarm follows the trip after the nominal delay, drops on clear at once
	// a fault seen while delaying or alarmed does not restart the delay
	always_comb begin
		next_state = state;
		next_delay_cnt = delay_cnt;
		next_alarm = alarm;
		case (state)
			TAO_IDLE: begin
				if (fault_event_in) begin
					next_state = TAO_DELAY;
					next_delay_cnt = 32'h0;
				end
			end
			TAO_DELAY: begin
				if (clear_taken) begin
					next_state = TAO_IDLE; // R10
				end else if (delay_cnt == DELAY_LAST) begin
					next_state = TAO_ALARM;
					next_alarm = 1'b1; // R3
				end else begin
					next_delay_cnt = delay_cnt + 32'h1;
				end
			end
			TAO_ALARM: begin
				if (clear_taken) begin
					next_state = TAO_IDLE;
					next_alarm = 1'b0; // R10
				end
			end
			default: begin
				next_state = TAO_IDLE;
				next_alarm = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state <= TAO_IDLE;
			delay_cnt <= 32'h0;
			alarm <= 1'b0;
		end else if (clk_en_in) begin
			state <= next_state;
			delay_cnt <= next_delay_cnt;
			alarm <= next_alarm; // R1
		end
	end

	// power-up hold-off before a normally closed relay may pull in
	// the counter stops once done, so it never wraps into a second hold-off
	always_comb begin
		next_start_cnt = start_cnt;
		next_started = started;
		if (!started) begin
			if (start_cnt == START_LAST) begin
				next_started = 1'b1; // R6
			end else begin
				next_start_cnt = start_cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			start_cnt <= 32'h0;
			started <= 1'b0;
		end else if (clk_en_in) begin
			start_cnt <= next_start_cnt;
			started <= next_started;
		end
	end

	// relay drive from its selected function and polarity
	always_comb begin
		if (relay_function_select_in == tao_pkg::FUNC_ALARM) begin // R4
			if (relay_polarity_select_in == tao_pkg::POL_NORM_OPEN) begin
				relay_on = alarm; // R8
			end else begin
				// any code other than normally open keeps the safe default
				relay_on = started && !alarm; // R5 R7
			end
		end else begin
			relay_on = 1'b0;
		end
	end

	// outputs registered so no glitch from the select decode reaches a pin
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			trip_state_out <= 1'b0;
		end else if (clk_en_in) begin
			trip_state_out <= trip; // R1
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			trip_alarm_function_out <= 1'b0;
		end else if (clk_en_in) begin
			trip_alarm_function_out <= alarm; // R1
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			relay_energise_out <= 1'b0;
		end else if (clk_en_in) begin
			relay_energise_out <= relay_on; // R4
		end
	end

	// open-collector terminals; one selected for another function stays off here
	assign term_select[0] = output_one_function_select_in;
	assign term_select[1] = output_two_function_select_in;

	for (genvar t = 0; t < OUT_COUNT; t++) begin : g_term
		always_ff @(posedge clk_sys_in) begin
			if (sys_rst_in) begin
				term_out[t] <= 1'b0;
			end else if (clk_en_in) begin
				term_out[t] <= alarm && (term_select[t] == tao_pkg::FUNC_ALARM); // R2
			end
		end
	end

	assign output_one_out = term_out[0];
	assign output_two_out = term_out[1];
endmodule
`default_nettype wire

// *** hw/tao_pkg.sv ***
package tao_pkg;
	// output function selection codes
	localparam logic [7:0] FUNC_ALARM = 8'h05;
	// relay polarity codes: 01 normally closed (default), 00 normally open
	localparam logic [7:0] POL_NORM_CLOSED = 8'h01;
	localparam logic [7:0] POL_NORM_OPEN = 8'h00;
	localparam logic [7:0] RST_OUT_ONE_FUNC = 8'h00;
	localparam logic [7:0] RST_OUT_TWO_FUNC = 8'h00;
	localparam logic [7:0] RST_RELAY_FUNC = FUNC_ALARM;
	localparam logic [7:0] RST_RELAY_POL = POL_NORM_CLOSED;
	// timing
	localparam int CLK_HZ = 50000000;
	localparam int ALARM_DELAY_MS = 300;
	localparam int STARTUP_DELAY_MS = 1000;
	localparam int ALARM_DELAY_CYC = CLK_HZ / 1000 * ALARM_DELAY_MS;
	localparam int STARTUP_DELAY_CYC = CLK_HZ / 1000 * STARTUP_DELAY_MS;
	localparam int MAX_STARTUP_CYC = CLK_HZ / 1000 * 2000 - 1;
endpackage

// *** sim/tao_alarm_loop.sv ***
`timescale 1ns/10ps
`default_nettype none
module tao_alarm_loop (
	input wire logic coil_in,
	input wire logic nc_in,
	output logic closed_out
);
	// closed loop reads as no alarm, so a cut wire alarms as well
	assign closed_out = nc_in ? coil_in : !coil_in;
endmodule
`default_nettype wire

// *** sim/tao_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module tao_chk #(parameter int ALARM_DELAY_CYC = 5, parameter int STARTUP_DELAY_CYC = 8) (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic fault_event_in,
	input wire logic fault_clear_in,
	input wire logic trip_state_out,
	input wire logic trip_alarm_function_out,
	input wire logic output_one_out,
	input wire logic relay_energise_out,
	input wire logic [7:0] output_one_function_select_in,
	input wire logic [7:0] relay_function_select_in,
	input wire logic [7:0] relay_polarity_select_in
);
	wire al = trip_alarm_function_out, re = relay_energise_out;
	wire ok = relay_function_select_in == 8'h05, nc = |relay_polarity_select_in;
	logic [7:0] n;
	// saturates so a long run never wraps back into the startup window
	always_ff @(posedge clk_sys_in) n <= sys_rst_in ? 8'h00 : n + {7'h00, n != 8'hff};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_clr; fault_clear_in && !fault_event_in && al; endsequence
	property p_trip; $rose(trip_state_out) |-> $past(fault_event_in, 2); endproperty
	a_trip: assert property (p_trip) else $error("trip");
	property p_out; output_one_out == (al && $past(output_one_function_select_in) == 8'h05);
	endproperty
	a_out: assert property (p_out) else $error("out");
	property p_dly; $rose(al) |-> $past(trip_state_out, ALARM_DELAY_CYC) &&
		!$past(trip_state_out, ALARM_DELAY_CYC + 1); endproperty
	a_dly: assert property (p_dly) else $error("delay");
	property p_clr; s_clr |-> ##[2:3] !al; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_nc; $rose(al) && nc && ok && $past(re) |-> !re; endproperty
	a_nc: assert property (p_nc) else $error("nc");
	property p_no; $stable(relay_polarity_select_in) && $stable(relay_function_select_in) &&
		!nc && ok |-> re == al; endproperty
	a_no: assert property (p_no) else $error("no");
	property p_up; n < STARTUP_DELAY_CYC |-> !re; endproperty
	a_up: assert property (p_up) else $error("early");
	property p_on; n == STARTUP_DELAY_CYC + 2 && nc && ok && !trip_state_out |-> re; endproperty
	a_on: assert property (p_on) else $error("late");
endmodule
bind tao_trip_alarm_output tao_chk #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC),
	.STARTUP_DELAY_CYC(STARTUP_DELAY_CYC)) chk (.*);
`default_nettype wire

// *** sim/tao_trip_alarm_output_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module tao_trip_alarm_output_test;
	logic c = 0, rs = 1, fe = 0, fc = 0, t, al, o1, o2, re, cl;
	logic [7:0] s1 = 0, s2 = 0, fn = 8'h05, pol = 8'h01;
	logic [15:0] r = 16'h58a0;
	logic [4:0] q[$];
	logic qt[$];
	int num_errors = 0, check_count = 0, cyc = 0;
	always #10 c = !c;
	tao_trip_alarm_output #(.ALARM_DELAY_CYC(5), .STARTUP_DELAY_CYC(8)) DUT (.clk_sys_in(c),
		.sys_rst_in(rs), .clk_en_in(1'b1), .fault_event_in(fe), .fault_clear_in(fc),
		.output_one_function_select_in(s1), .output_two_function_select_in(s2),
		.relay_function_select_in(fn), .relay_polarity_select_in(pol), .trip_state_out(t),
		.trip_alarm_function_out(al), .output_one_out(o1), .output_two_out(o2),
		.relay_energise_out(re));
	tao_alarm_loop LOOP (.coil_in(re), .nc_in(pol != 8'h00), .closed_out(cl));
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], ^(x & 16'hb400)};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge c);
		#2;
	endtask
	task automatic compare(input logic [4:0] e);
		check_count++;
		if (e !== {al, o1, o2, re, cl}) begin
			num_errors++;
			$display("[ERR] outputs expected %b seen %b", e, {al, o1, o2, re, cl});
		end
	endtask
	task automatic compare_trip(input logic e);
		check_count++;
		if (e !== t) begin
			num_errors++;
			$display("[ERR] trip_state expected %b seen %b", e, t);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge c) if (++cyc == 600) begin
		num_errors++;
		report_and_stop();
	end
	always @(al) if (!rs) #1 compare(q.pop_front());
	always @(t) if (!rs) #1 compare_trip(qt.pop_front());
	initial begin
		tick(4);
		rs = 0;
		tick(12);
		for (int i = 0; i < 4; i++) begin
			r = nx(r);
			pol = {7'h00, !i[0]};
			fn = i == 3 ? 8'h2a : 8'h05;
			s1 = i[1] ? 8'h05 : {4'h0, r[3:0]};
			s2 = {5'h00, r[6:4]};
			tick(2 + r[9:8]);
			q.push_back({1'b1, s1 == 8'h05, s2 == 8'h05, i == 1, i == 3});
			q.push_back({3'b000, !i[0], 1'b1});
			qt.push_back(1'b1);
			qt.push_back(1'b0);
			fe = 1;
			tick(1);
			fe = 0;
			tick(12);
			// a repeated fault while latched must not restart the delay
			fe = 1;
			tick(1);
			{fe, fc} = 2'b01;
			tick(1);
			fc = 0;
			tick(6);
			$display("test %0d done", i);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
